// file: shared/ibr_consts.vh
`ifndef IBR_CONSTS_VH
`define IBR_CONSTS_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define IBR_OFF_CTRL     12'h000
`define IBR_OFF_STATUS   12'h004
`define IBR_OFF_IRQ      12'h008
`define IBR_OFF_CFG      12'h00c
`define IBR_OFF_TXDATA   12'h010
// ----------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------
`define IBR_CTRL_JOIN_REQ 0
`define IBR_CTRL_IBI_REQ  1
`define IBR_CTRL_TX_RST   2
`define IBR_CTRL_ACTIVE   3
// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define IBR_IRQ_JOIN_GEN  0
`define IBR_IRQ_JOIN_DONE 1
`define IBR_IRQ_JOIN_NACK 2
`define IBR_IRQ_IBI_GEN   3
`define IBR_IRQ_IBI_DONE  4
`define IBR_IRQ_IBI_NACK  5
`define IBR_IRQ_PAYLD_TRM 6
`define IBR_IRQ_WIDTH     7
// ----------------------------------------------------------------
// Bus constants and reset values
// ----------------------------------------------------------------
`define IBR_JOIN_ADDR     7'h02
`define IBR_BCAST_ADDR    7'h7e
`define IBR_PEND_MDB      3'b101
`define IBR_RETRY_RESET   4'h3
`define IBR_MAXPLD_RESET  8'h08
`define IBR_DYNADDR_RESET 7'h08
`define IBR_QBIT_CYCLES   4'h4
`endif

// file: hdl/ibr_txmem.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Transmit FIFO with registered read data
// ----------------------------------------------------------------
module ibr_txmem #(
  parameter DEPTH_LOG2 = 4
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       flush,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  input  wire       rd_en,
  output reg  [7:0] rd_data,
  output wire       empty,
  output wire       full
);
  reg [7:0]          mem [0:(1<<DEPTH_LOG2)-1];
  reg [DEPTH_LOG2:0] wptr;
  reg [DEPTH_LOG2:0] rptr;

  assign empty = (wptr == rptr);
  assign full  = (wptr[DEPTH_LOG2] != rptr[DEPTH_LOG2]) &&
                 (wptr[DEPTH_LOG2-1:0] == rptr[DEPTH_LOG2-1:0]);

  always @(posedge clk) begin
    if (wr_en && !full) begin
      mem[wptr[DEPTH_LOG2-1:0]] <= wr_data;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr    <= {(DEPTH_LOG2+1){1'b0}};
      rptr    <= {(DEPTH_LOG2+1){1'b0}};
      rd_data <= 8'h00;
    end else if (flush) begin
      wptr <= {(DEPTH_LOG2+1){1'b0}};
      rptr <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      if (wr_en && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (rd_en && !empty) begin
        rd_data <= mem[rptr[DEPTH_LOG2-1:0]];
        rptr    <= rptr + 1'b1;
      end
    end
  end
endmodule // ibr_txmem

// file: hdl/ibr_request.v
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "ibr_consts.vh"
module ibr_request #(
  parameter JOIN_CAPABLE = 1,
  parameter IBI_CAPABLE  = 1,
  parameter FIFO_LOG2    = 4
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        bus_idle,
  input  wire        bus_available,
  input  wire        join_permitted_flag,
  input  wire        interrupt_permitted_flag,
  input  wire        payload_capable,
  input  wire        dyn_addr_valid,
  input  wire        private_read_done,
  output reg         pending_read_active,
  output reg         await_dyn_addr
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SLOW = 7'h02;
  localparam [6:0] S_ADDR = 7'h04;
  localparam [6:0] S_ACK  = 7'h08;
  localparam [6:0] S_DATA = 7'h10;
  localparam [6:0] S_TBIT = 7'h20;
  localparam [6:0] S_END  = 7'h40;

  reg [6:0]  state;
  reg        join_request_bit;
  reg        ibi_req;
  reg        active_mode;
  reg [3:0]  request_retry_limit;
  reg [7:0]  max_payload;
  reg [6:0]  dyn_addr;
  reg [`IBR_IRQ_WIDTH-1:0] irq;
  reg        i3c_bus_seen;
  reg        is_join;
  reg [3:0]  nack_count;
  reg [7:0]  shreg;
  reg [3:0]  bitcnt;
  reg [7:0]  sent;
  reg        scl_d;
  reg        sda_d;
  reg        pend_mdb;
  reg        fifo_rd;
  reg        fifo_ld;
  reg        rd_hit;
  reg [`IBR_IRQ_WIDTH-1:0] irq_set;

  wire       fifo_empty;
  wire       fifo_full;
  wire [7:0] fifo_data;

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  wire start_det = scl_in && sda_d && !sda_in;
  wire stop_det  = scl_in && !sda_d && sda_in;
  wire scl_rise  = scl_in && !scl_d;
  wire scl_fall  = !scl_in && scl_d;

  wire join_en = (JOIN_CAPABLE != 0);
  wire ibi_en  = (IBI_CAPABLE != 0);

  // Own header byte: address then direction bit
  function [7:0] hdr_byte;
    input jn;
    input [6:0] da;
    begin
      hdr_byte = jn ? {`IBR_JOIN_ADDR, 1'b0} : {da, 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && !penable && !pwrite;
  wire known  = (paddr == `IBR_OFF_CTRL) || (paddr == `IBR_OFF_STATUS) ||
                (paddr == `IBR_OFF_IRQ) || (paddr == `IBR_OFF_CFG) ||
                (paddr == `IBR_OFF_TXDATA);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;
  wire tx_wr = wr_acc && (paddr == `IBR_OFF_TXDATA);
  wire ctl_wr = wr_acc && (paddr == `IBR_OFF_CTRL);
  wire tx_rst = ctl_wr && pwdata[`IBR_CTRL_TX_RST];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (rd_acc) begin
      case (paddr)
        `IBR_OFF_CTRL:   prdata <= {28'h0000000, active_mode, 1'b0,
                                    ibi_req, join_request_bit};
        `IBR_OFF_STATUS: prdata <= {19'h00000, nack_count, state,
                                    pending_read_active, i3c_bus_seen};
        `IBR_OFF_IRQ:    prdata <= {25'h0000000, irq};
        `IBR_OFF_CFG:    prdata <= {9'h000, dyn_addr, max_payload,
                                    4'h0, request_retry_limit};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  ibr_txmem #(.DEPTH_LOG2(FIFO_LOG2)) u_txmem (
    .clk     (clk),
    .rstn    (rstn),
    .flush   (tx_rst),
    .wr_en   (tx_wr),
    .wr_data (pwdata[7:0]),
    .rd_en   (fifo_rd),
    .rd_data (fifo_data),
    .empty   (fifo_empty),
    .full    (fifo_full)
  );

  // ----------------------------------------------------------------
  // Request engine
  // ----------------------------------------------------------------
  wire join_go = join_en && join_request_bit && (i3c_bus_seen || active_mode);
  wire ibi_go  = ibi_en && ibi_req && dyn_addr_valid &&
                 !(pending_read_active && !fifo_empty &&
                   fifo_data[7:5] == `IBR_PEND_MDB);
  wire retry_hit = (nack_count + 4'h1) >= request_retry_limit;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state        <= S_IDLE;
      i3c_bus_seen <= 1'b0;
      is_join      <= 1'b0;
      nack_count   <= 4'h0;
      shreg        <= 8'h00;
      bitcnt       <= 4'h0;
      sent         <= 8'h00;
      scl_d        <= 1'b1;
      sda_d        <= 1'b1;
      sda_out      <= 1'b1;
      sda_oe       <= 1'b0;
      pend_mdb     <= 1'b0;
      fifo_rd      <= 1'b0;
      fifo_ld      <= 1'b0;
      rd_hit       <= 1'b0;
      irq_set      <= {`IBR_IRQ_WIDTH{1'b0}};
      pending_read_active <= 1'b0;
      await_dyn_addr      <= 1'b0;
    end else begin
      scl_d   <= scl_in;
      sda_d   <= sda_in;
      fifo_rd <= 1'b0;
      // FIFO read data is registered: load the byte one cycle later
      fifo_ld <= fifo_rd;
      rd_hit  <= fifo_rd && !fifo_empty;
      irq_set <= {`IBR_IRQ_WIDTH{1'b0}};
      if (private_read_done) begin
        pending_read_active <= 1'b0;
      end
      if (dyn_addr_valid) begin
        await_dyn_addr <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          sda_oe <= 1'b0;
          if ((join_go || ibi_go) && active_mode &&
              (bus_idle || bus_available)) begin
            sda_oe  <= 1'b1;
            sda_out <= 1'b0;
            is_join <= join_go;
            state   <= S_SLOW;
          end else if ((join_go || ibi_go) && start_det) begin
            is_join <= join_go;
            shreg   <= hdr_byte(join_go, dyn_addr);
            bitcnt  <= 4'h0;
            state   <= S_ADDR;
          end
        end
        S_SLOW: begin
          if (scl_fall) begin
            shreg  <= hdr_byte(is_join, dyn_addr);
            bitcnt <= 4'h0;
            state  <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (!scl_in) begin
            sda_oe  <= !shreg[7];
            sda_out <= 1'b0;
          end
          if (scl_rise) begin
            if (shreg[7] && !sda_in) begin
              sda_oe <= 1'b0;
              state  <= S_IDLE;
            end else if (bitcnt == 4'h7) begin
              irq_set[is_join ? `IBR_IRQ_JOIN_GEN
                              : `IBR_IRQ_IBI_GEN] <= 1'b1;
              state <= S_ACK;
            end else begin
              shreg  <= {shreg[6:0], 1'b1};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        S_ACK: begin
          if (!scl_in) begin
            sda_oe <= 1'b0;
          end
          if (scl_rise) begin
            if (sda_in) begin
              nack_count <= retry_hit ? 4'h0 : nack_count + 4'h1;
              if (is_join) begin
                irq_set[`IBR_IRQ_JOIN_NACK] <= 1'b1;
                irq_set[`IBR_IRQ_JOIN_DONE] <= retry_hit;
              end else begin
                irq_set[`IBR_IRQ_IBI_NACK] <= 1'b1;
                irq_set[`IBR_IRQ_IBI_DONE] <= retry_hit;
              end
              state <= S_END;
            end else begin
              nack_count <= 4'h0;
              sent       <= 8'h00;
              if (is_join) begin
                irq_set[`IBR_IRQ_JOIN_DONE] <= 1'b1;
                await_dyn_addr <= !dyn_addr_valid;
                state <= S_END;
              end else if (!payload_capable) begin
                irq_set[`IBR_IRQ_IBI_DONE] <= 1'b1;
                state <= S_END;
              end else begin
                fifo_rd  <= 1'b1;
                pend_mdb <= 1'b1;
                bitcnt   <= 4'h0;
                state    <= S_DATA;
              end
            end
          end
        end
        S_DATA: begin
          // Empty FIFO sends all ones
          if (fifo_ld) begin
            shreg    <= rd_hit ? fifo_data : 8'hff;
            pend_mdb <= pend_mdb && rd_hit &&
                        (fifo_data[7:5] == `IBR_PEND_MDB);
          end
          if (!scl_in && !fifo_rd && !fifo_ld) begin
            sda_oe  <= 1'b1;
            sda_out <= shreg[7];
          end
          if (scl_rise) begin
            if (bitcnt == 4'h7) begin
              if (pend_mdb) begin
                pending_read_active <= 1'b1;
              end
              pend_mdb <= 1'b0;
              sent     <= sent + 8'h01;
              state    <= S_TBIT;
            end else begin
              shreg  <= {shreg[6:0], 1'b1};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        S_TBIT: begin
          if (!scl_in) begin
            sda_oe  <= 1'b1;
            sda_out <= !((sent >= max_payload) || fifo_empty);
          end
          if (scl_rise) begin
            sda_oe <= 1'b0;
            if ((sent >= max_payload) || fifo_empty) begin
              irq_set[`IBR_IRQ_IBI_DONE] <= 1'b1;
              state <= S_END;
            end else if (!sda_in) begin
              irq_set[`IBR_IRQ_IBI_DONE]  <= 1'b1;
              irq_set[`IBR_IRQ_PAYLD_TRM] <= 1'b1;
              state <= S_END;
            end else begin
              fifo_rd <= 1'b1;
              bitcnt  <= 4'h0;
              state   <= S_DATA;
            end
          end
        end
        S_END: begin
          sda_oe <= 1'b0;
          if (stop_det || start_det || bus_idle) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      if (state == S_IDLE && scl_rise && bitcnt == 4'h7 &&
          shreg[6:0] == `IBR_BCAST_ADDR) begin
        i3c_bus_seen <= 1'b1;
      end
      // Header monitor must not clobber a request launched at START
      if (state == S_IDLE && !(start_det && (join_go || ibi_go))) begin
        if (start_det) begin
          bitcnt <= 4'h0;
          shreg  <= 8'h00;
        end else if (scl_rise && bitcnt != 4'h8) begin
          shreg  <= {shreg[6:0], sda_in};
          bitcnt <= bitcnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  wire req_done_j = irq_set[`IBR_IRQ_JOIN_DONE];
  wire req_done_i = irq_set[`IBR_IRQ_IBI_DONE];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      join_request_bit    <= 1'b0;
      ibi_req             <= 1'b0;
      active_mode         <= 1'b0;
      request_retry_limit <= `IBR_RETRY_RESET;
      max_payload         <= `IBR_MAXPLD_RESET;
      dyn_addr            <= `IBR_DYNADDR_RESET;
      irq                 <= {`IBR_IRQ_WIDTH{1'b0}};
    end else begin
      if (ctl_wr) begin
        join_request_bit <= pwdata[`IBR_CTRL_JOIN_REQ] && join_en
                            && join_permitted_flag;
        ibi_req <= pwdata[`IBR_CTRL_IBI_REQ] && ibi_en
                   && interrupt_permitted_flag;
        active_mode <= pwdata[`IBR_CTRL_ACTIVE];
      end else begin
        if (req_done_j) begin
          join_request_bit <= 1'b0;
        end
        if (req_done_i) begin
          ibi_req <= 1'b0;
        end
      end
      if (wr_acc && paddr == `IBR_OFF_CFG) begin
        request_retry_limit <= pwdata[3:0];
        max_payload         <= pwdata[15:8];
        dyn_addr            <= pwdata[22:16];
      end
      // Write one to clear; a new event in the same cycle wins
      if (wr_acc && paddr == `IBR_OFF_IRQ) begin
        irq <= (irq & ~pwdata[`IBR_IRQ_WIDTH-1:0]) | irq_set;
      end else begin
        irq <= irq | irq_set;
      end
    end
  end
endmodule // ibr_request

// file: verif/ibr_request_asserts.sv
`timescale 1ns/100ps
module ibr_request_asserts (
  input wire        clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        bus_idle,
  input wire        bus_available,
  input wire        dyn_addr_valid,
  input wire        private_read_done,
  input wire        pending_read_active,
  input wire        await_dyn_addr
);
  wire unmapped = paddr > 12'h010 || paddr[1:0] != 2'b00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (psel && penable |-> pslverr == unmapped)
    else $error("pslverr does not match address map");
  a_rdata_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata changed outside read setup");
  a_data_steady: assert property (
    sda_oe && $past(sda_oe) && scl_in && $past(scl_in) |-> $stable(sda_out))
    else $error("sda_out changed while scl high");
  a_start_on_idle: assert property (
    $rose(sda_oe) && scl_in |-> $past(bus_idle || bus_available))
    else $error("sda driven at scl high without idle bus");
  a_pend_clear: assert property (
    private_read_done |=> !pending_read_active)
    else $error("pending notice not cleared by private read");
  a_pend_hold: assert property (
    pending_read_active && !private_read_done |=> pending_read_active)
    else $error("pending notice dropped before private read");
  a_await_clear: assert property (
    dyn_addr_valid && $past(dyn_addr_valid) |-> !await_dyn_addr)
    else $error("await_dyn_addr held after address assigned");
endmodule // ibr_request_asserts

bind ibr_request ibr_request_asserts ibr_request_asserts_inst (
  .clk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .scl_in, .sda_out, .sda_oe, .bus_idle, .bus_available,
  .dyn_addr_valid, .private_read_done, .pending_read_active,
  .await_dyn_addr
);

// file: verif/ibr_ctrl_model.sv
`timescale 1ns/100ps
module ibr_ctrl_model #(
  parameter H = 8
) (
  input  wire clk,
  input  wire dev_out,
  input  wire dev_oe,
  output reg  scl,
  output wire sda
);
  localparam [7:0] BC = 8'hfc;
  reg         ctl;
  reg         rvl;
  logic [7:0] rdq [$];
  // Open-drain wire with pull-up; device data ones are push-pull
  assign sda = ctl & rvl & (dev_oe ? dev_out : 1'b1);
  initial begin
    scl = 1'b1;
    ctl = 1'b1;
    rvl = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bitx(input bit c, input bit r, output bit s);
    ctl <= c;
    rvl <= r;
    hp(H);
    scl <= 1'b1;
    // Sample right after the rise: the target lets go of a T-bit there
    @(negedge clk);
    s = sda;
    hp(H);
    scl <= 1'b0;
  endtask
  // One frame; ab < 0 skips the payload, else abort at byte ab
  task automatic frame(input bit act, input [7:0] rv, input bit ack,
                       input int ab, output [7:0] hdr, output bit err);
    bit         cx;
    bit         rx;
    bit         s;
    int         i;
    int         b;
    logic [7:0] d;
    err = 1'b0;
    cx = 1'b1;
    rx = 1'b1;
    rdq = {};
    if (act) begin
      i = 0;
      while (sda !== 1'b0 && i < 400) begin
        hp(1);
        i++;
      end
      err = (sda !== 1'b0);
    end else begin
      ctl <= 1'b0;
    end
    hp(H);
    scl <= 1'b0;
    for (i = 0; i < 8; i++) begin
      bitx(cx ? BC[7-i] : 1'b1, rx ? rv[7-i] : 1'b1, s);
      hdr[7-i] = s;
      cx = cx && !(BC[7-i] && !s);
      rx = rx && !(rv[7-i] && !s);
    end
    bitx(!(ack && hdr != BC), 1'b1, s);
    if (ack && hdr[0] && ab >= 0) begin
      for (b = 0; b < 16; b++) begin
        for (i = 0; i < 8; i++) begin
          bitx(1'b1, 1'b1, s);
          d = {d[6:0], s};
        end
        bitx(b != ab, 1'b1, s);
        rdq.push_back(d);
        if (!s) break;
      end
    end
    ctl <= 1'b0;
    hp(H);
    scl <= 1'b1;
    hp(H);
    ctl <= 1'b1;
    hp(H);
  endtask
endmodule // ibr_ctrl_model

// file: verif/ibr_request_tb_top.sv
`timescale 1ns/100ps
`include "ibr_consts.vh"
module ibr_request_tb_top;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scl_in, sda_in, sda_out, sda_oe, bus_available, bus_idle;
  logic        join_permitted_flag, interrupt_permitted_flag;
  logic        payload_capable, dyn_addr_valid, private_read_done;
  logic        pending_read_active, await_dyn_addr, err;
  logic [7:0]  hdr, b0, b1;
  int          n_mismatch, n_checks, lim, k, n;

  always #12.5 clk = ~clk;

  ibr_request ibr_request_inst (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe,
    .bus_idle, .bus_available, .join_permitted_flag,
    .interrupt_permitted_flag, .payload_capable, .dyn_addr_valid,
    .private_read_done, .pending_read_active, .await_dyn_addr
  );
  ibr_ctrl_model ibr_ctrl_model_inst (
    .clk, .dev_out(sda_out), .dev_oe(sda_oe), .scl(scl_in), .sda(sda_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input [11:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic fr(input bit act, input [7:0] rv, input bit ack,
                    input int ab, input [7:0] eh);
    ibr_ctrl_model_inst.frame(act, rv, ack, ab, hdr, err);
    chk({err, hdr}, {1'b0, eh});
    repeat (20) @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    {clk, rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bus_available, join_permitted_flag, interrupt_permitted_flag} = '0;
    bus_idle = 1'b0;
    {payload_capable, dyn_addr_valid, private_read_done} = '0;
    void'($urandom(32761));
    repeat (2) @(posedge clk);
    chk({sda_oe, sda_out, pending_read_active, await_dyn_addr}, 4'b0100);
    rstn <= 1'b1;
    rdc(`IBR_OFF_CFG, 32'h0008_0803);
    rdc(12'h020, 32'h0);
    join_permitted_flag <= 1'b1;
    apb(1'b1, `IBR_OFF_CTRL, 32'h1);
    fr(1'b0, 8'hff, 1'b0, -1, 8'hfc);
    apb(1'b0, `IBR_OFF_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    fr(1'b0, 8'h02, 1'b0, -1, 8'h02);
    rdc(`IBR_OFF_IRQ, 32'h0);
    lim = 1 + $urandom % 3;
    apb(1'b1, `IBR_OFF_CFG, {9'h0, 7'h08, 8'h08, 4'h0, lim[3:0]});
    // Nack up to the limit, then a fresh request that is acknowledged
    for (k = 0; k < 2; k++) begin
      if (k) begin
        dyn_addr_valid <= 1'b1;
        interrupt_permitted_flag <= 1'b1;
        apb(1'b1, `IBR_OFF_CTRL, 32'h2);
      end
      for (n = 1; n <= lim; n++) begin
        fr(1'b0, 8'hff, 1'b0, -1, k ? 8'h11 : 8'h04);
        rdc(`IBR_OFF_IRQ, (n == lim ? 7 : 5) << (3 * k));
        apb(1'b1, `IBR_OFF_IRQ, 32'h7f);
      end
      fr(1'b0, 8'hff, 1'b0, -1, 8'hfc);
      apb(1'b1, `IBR_OFF_CTRL, k ? 32'h2 : 32'h1);
      fr(1'b0, 8'hff, 1'b1, -1, k ? 8'h11 : 8'h04);
      rdc(`IBR_OFF_IRQ, 3 << (3 * k));
      apb(1'b1, `IBR_OFF_IRQ, 32'h7f);
      chk(await_dyn_addr, !k);
    end
    // Active join on an idle bus
    bus_idle <= 1'b1;
    apb(1'b1, `IBR_OFF_CTRL, 32'h9);
    fr(1'b1, 8'hff, 1'b1, -1, 8'h04);
    bus_idle <= 1'b0;
    rdc(`IBR_OFF_IRQ, 32'h3);
    apb(1'b1, `IBR_OFF_IRQ, 32'h7f);
    payload_capable <= 1'b1;
    bus_available <= 1'b1;
    b0 = {3'b010, 5'($urandom)};
    b1 = 8'($urandom);
    apb(1'b1, `IBR_OFF_TXDATA, {24'h0, b0});
    apb(1'b1, `IBR_OFF_TXDATA, {24'h0, b1});
    apb(1'b1, `IBR_OFF_CTRL, 32'ha);
    fr(1'b1, 8'hff, 1'b1, 99, 8'h11);
    chk(32'(ibr_ctrl_model_inst.rdq.size()), 2);
    chk({ibr_ctrl_model_inst.rdq[0], ibr_ctrl_model_inst.rdq[1]}, {b0, b1});
    rdc(`IBR_OFF_IRQ, 32'h18);
    bus_available <= 1'b0;
    apb(1'b1, `IBR_OFF_IRQ, 32'h7f);
    for (n = 0; n < 3; n++)
      apb(1'b1, `IBR_OFF_TXDATA, {24'h0, 3'b011, 5'($urandom)});
    apb(1'b1, `IBR_OFF_CTRL, 32'h2);
    fr(1'b0, 8'hff, 1'b1, 0, 8'h11);
    chk(32'(ibr_ctrl_model_inst.rdq.size()), 1);
    rdc(`IBR_OFF_IRQ, 32'h58);
    apb(1'b1, `IBR_OFF_CTRL, 32'h4);
    apb(1'b1, `IBR_OFF_IRQ, 32'h7f);
    apb(1'b1, `IBR_OFF_TXDATA, 32'hb5);
    apb(1'b1, `IBR_OFF_CTRL, 32'h2);
    fr(1'b0, 8'hff, 1'b1, 99, 8'h11);
    chk(pending_read_active, 1'b1);
    apb(1'b1, `IBR_OFF_TXDATA, 32'hb6);
    apb(1'b1, `IBR_OFF_CTRL, 32'h2);
    fr(1'b0, 8'hff, 1'b0, -1, 8'hfc);
    private_read_done <= 1'b1;
    @(posedge clk);
    private_read_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pending_read_active, 1'b0);
    end_sim;
  end
endmodule // ibr_request_tb_top
